//--- design/mptb_pkg.sv
// constants, types and layouts for the motor pwm time base
package mptb_pkg;

	localparam int unsigned MPTB_DATA_W = 16;
	localparam int unsigned MPTB_ADDR_W = 4;

	// register indices on the plain register port
	localparam logic [3:0] MPTB_REG_CONTROL = 4'h0;
	localparam logic [3:0] MPTB_REG_COUNT = 4'h1;
	localparam logic [3:0] MPTB_REG_PERIOD = 4'h2;
	localparam logic [3:0] MPTB_REG_EVENT_CMP = 4'h3;
	localparam logic [3:0] MPTB_REG_DUTY1 = 4'h4;
	localparam logic [3:0] MPTB_REG_DUTY2 = 4'h5;
	localparam logic [3:0] MPTB_REG_DUTY3 = 4'h6;
	localparam logic [3:0] MPTB_REG_STATUS = 4'h7;
	localparam logic [3:0] MPTB_REG_MASK = 4'h8;

	// status and mask bit positions
	localparam int unsigned MPTB_ST_TB_EVENT = 0;
	localparam int unsigned MPTB_ST_SPECIAL = 1;
	localparam int unsigned MPTB_ST_W = 2;

	// count register direction bit
	localparam int unsigned MPTB_DIR_BIT = 15;

	// reset values
	localparam logic [15:0] MPTB_CONTROL_RST = 16'h0000;
	localparam logic [14:0] MPTB_PERIOD_RST = 15'h0000;
	localparam logic [14:0] MPTB_ZERO15 = 15'h0000;
	localparam logic [14:0] MPTB_ONE15 = 15'h0001;

	// prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
	localparam int unsigned MPTB_PRE_W = 6;
	localparam logic [5:0] MPTB_PRE_DIV1 = 6'h00;
	localparam logic [5:0] MPTB_PRE_DIV4 = 6'h03;
	localparam logic [5:0] MPTB_PRE_DIV16 = 6'h0F;
	localparam logic [5:0] MPTB_PRE_DIV64 = 6'h3F;

	typedef enum logic [1:0] {
		MPTB_MODE_FREE = 2'h0,
		MPTB_MODE_SINGLE = 2'h1,
		MPTB_MODE_UPDOWN = 2'h2,
		MPTB_MODE_DOUBLE = 2'h3
	} mptb_mode_e;

	// control register layout: bit 15 enable, 7:4 postscale, 3:2 prescale, 1:0 mode
	typedef struct packed {
		logic time_base_on;
		logic [6:0] unused;
		logic [3:0] event_divider_sel;
		logic [1:0] clock_divider_sel;
		mptb_mode_e time_base_mode_sel;
	} mptb_ctrl_s;

	// state of the counter that travels together
	typedef struct packed {
		logic count_down_flag;
		logic [14:0] time_base_count;
	} mptb_count_s;

endpackage

//--- design/mptb_postscaler.sv
// event postscaler for the time base interrupt
`timescale 1ns/10ps
module mptb_postscaler (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic clear_in,
	input wire logic bypass_in,
	input wire logic event_in,
	input wire logic [3:0] event_divider_sel_in,
	output logic event_out
);

	logic [3:0] post_count;

	assign event_out = event_in && (bypass_in || post_count == event_divider_sel_in);

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			post_count <= 4'h0;
		end else if (clear_in) begin
			post_count <= 4'h0;
		end else if (event_in && !bypass_in) begin
			if (post_count == event_divider_sel_in) begin
				post_count <= 4'h0;
			end else begin
				post_count <= post_count + 4'h1;
			end
		end
	end

endmodule // mptb_postscaler

//--- design/mptb_prescaler.sv
// input clock prescaler for the time base counter
`timescale 1ns/10ps
module mptb_prescaler
	import mptb_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic clear_in,
	input wire logic [1:0] clock_divider_sel_in,
	output logic tick_out
);

	logic [MPTB_PRE_W-1:0] pre_count;
	logic [MPTB_PRE_W-1:0] limit;

	function automatic logic [MPTB_PRE_W-1:0] pre_limit(input logic [1:0] sel);
		unique case (sel)
			2'h0: pre_limit = MPTB_PRE_DIV1;
			2'h1: pre_limit = MPTB_PRE_DIV4;
			2'h2: pre_limit = MPTB_PRE_DIV16;
			2'h3: pre_limit = MPTB_PRE_DIV64;
		endcase
	endfunction

	assign limit = pre_limit(clock_divider_sel_in);
	assign tick_out = !clear_in && (pre_count == limit);

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pre_count <= '0;
		end else if (clear_in || pre_count == limit) begin
			pre_count <= '0;
		end else begin
			pre_count <= pre_count + 1'b1;
		end
	end

endmodule // mptb_prescaler

//--- design/mptb_time_base.sv
// motor pwm time base with three complementary output pairs
`timescale 1ns/10ps
module mptb_time_base
	import mptb_pkg::*;
#(
	parameter int unsigned CNT_W = 15
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [MPTB_ADDR_W-1:0] reg_addr_in,
	input wire logic [MPTB_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [MPTB_DATA_W-1:0] reg_rdata_out,
	output logic irq_out,
	output logic special_trigger_out,
	output logic pair1_high_out,
	output logic pair1_low_out,
	output logic pair2_high_out,
	output logic pair2_low_out,
	output logic pair3_high_out,
	output logic pair3_low_out
);

	if (CNT_W != 15) begin : g_width_check
		$error("mptb_time_base: counter layout serves only a 15-bit count");
	end

	mptb_ctrl_s ctrl;
	mptb_count_s cnt;
	logic [14:0] period_active;
	logic [14:0] period_buffer;
	logic [14:0] event_cmp;
	logic [14:0] duty [3];
	logic [MPTB_ST_W-1:0] status;
	logic [MPTB_ST_W-1:0] mask;

	logic wr_control;
	logic wr_count;
	logic wr_period;
	logic wr_status;
	logic scaler_clear;
	logic pre_tick;
	logic step;
	logic period_match;
	logic at_zero_turn;
	logic is_updown;
	logic raw_event;
	logic post_bypass;
	logic tb_event;
	logic special_hit;
	logic load_period;
	logic single_done;
	logic center_mode;
	logic [2:0] next_high;
	mptb_count_s next_cnt;

	// register write decode
	assign wr_control = reg_write_in && reg_addr_in == MPTB_REG_CONTROL;
	assign wr_count = reg_write_in && reg_addr_in == MPTB_REG_COUNT;
	assign wr_period = reg_write_in && reg_addr_in == MPTB_REG_PERIOD;
	assign wr_status = reg_write_in && reg_addr_in == MPTB_REG_STATUS;
	assign scaler_clear = wr_control || wr_count;

	mptb_prescaler u_prescaler (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.clear_in(scaler_clear),
		.clock_divider_sel_in(ctrl.clock_divider_sel),
		.tick_out(pre_tick)
	);

	// counting only while enabled and period non-zero
	assign step = pre_tick && ctrl.time_base_on && period_active != MPTB_ZERO15;
	assign is_updown = ctrl.time_base_mode_sel == MPTB_MODE_UPDOWN
		|| ctrl.time_base_mode_sel == MPTB_MODE_DOUBLE;
	assign period_match = cnt.time_base_count == period_active;
	assign at_zero_turn = is_updown && cnt.count_down_flag
		&& cnt.time_base_count <= MPTB_ONE15;

	always_comb begin
		next_cnt = cnt;
		if (is_updown) begin
			if (!cnt.count_down_flag) begin
				if (period_match) begin
					next_cnt.count_down_flag = 1'b1;
					next_cnt.time_base_count = cnt.time_base_count - MPTB_ONE15;
				end else begin
					next_cnt.time_base_count = cnt.time_base_count + MPTB_ONE15;
				end
			end else if (at_zero_turn) begin
				next_cnt.count_down_flag = 1'b0;
				next_cnt.time_base_count = MPTB_ZERO15;
			end else begin
				next_cnt.time_base_count = cnt.time_base_count - MPTB_ONE15;
			end
		end else begin
			next_cnt.count_down_flag = 1'b0;
			if (period_match) begin
				next_cnt.time_base_count = MPTB_ZERO15;
			end else begin
				next_cnt.time_base_count = cnt.time_base_count + MPTB_ONE15;
			end
		end
	end

	// raw interrupt events per mode
	always_comb begin
		raw_event = 1'b0;
		unique case (ctrl.time_base_mode_sel)
			MPTB_MODE_FREE: raw_event = step && period_match;
			MPTB_MODE_SINGLE: raw_event = step && period_match;
			MPTB_MODE_UPDOWN: raw_event = step && at_zero_turn;
			MPTB_MODE_DOUBLE: raw_event = step
				&& (at_zero_turn || (!cnt.count_down_flag && period_match));
		endcase
	end

	assign post_bypass = ctrl.time_base_mode_sel == MPTB_MODE_SINGLE
		|| ctrl.time_base_mode_sel == MPTB_MODE_DOUBLE;

	mptb_postscaler u_postscaler (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.clear_in(scaler_clear),
		.bypass_in(post_bypass),
		.event_in(raw_event),
		.event_divider_sel_in(ctrl.event_divider_sel),
		.event_out(tb_event)
	);

	assign single_done = step && period_match
		&& ctrl.time_base_mode_sel == MPTB_MODE_SINGLE;
	assign special_hit = step && cnt.time_base_count == event_cmp;

	// period reload points: counter restart, zero in up/down, or while disabled
	always_comb begin
		load_period = 1'b0;
		if (!ctrl.time_base_on) begin
			load_period = 1'b1;
		end else if (period_active != MPTB_ZERO15 && step) begin
			if (is_updown) begin
				load_period = at_zero_turn;
			end else begin
				load_period = period_match;
			end
		end
	end

	// control register; hardware clears enable at end of single shot
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl <= mptb_ctrl_s'(MPTB_CONTROL_RST);
		end else if (wr_control) begin
			ctrl <= mptb_ctrl_s'(reg_wdata_in);
			ctrl.unused <= '0;
		end else if (single_done) begin
			ctrl.time_base_on <= 1'b0;
		end
	end

	// counter; disable only stops it, never clears it
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt <= '0;
		end else if (wr_count) begin
			cnt.time_base_count <= reg_wdata_in[14:0];
		end else if (step) begin
			cnt <= next_cnt;
		end
	end

	// period buffer and active period
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			period_buffer <= MPTB_PERIOD_RST;
		end else if (wr_period) begin
			period_buffer <= reg_wdata_in[14:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			period_active <= MPTB_PERIOD_RST;
		end else if (load_period) begin
			period_active <= period_buffer;
		end
	end

	// compare and duty registers
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			event_cmp <= MPTB_ZERO15;
			duty[0] <= MPTB_ZERO15;
			duty[1] <= MPTB_ZERO15;
			duty[2] <= MPTB_ZERO15;
		end else if (reg_write_in) begin
			unique case (reg_addr_in)
				MPTB_REG_EVENT_CMP: event_cmp <= reg_wdata_in[14:0];
				MPTB_REG_DUTY1: duty[0] <= reg_wdata_in[14:0];
				MPTB_REG_DUTY2: duty[1] <= reg_wdata_in[14:0];
				MPTB_REG_DUTY3: duty[2] <= reg_wdata_in[14:0];
				default: ;
			endcase
		end
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			status <= '0;
		end else begin
			status[MPTB_ST_TB_EVENT] <= tb_event
				|| (status[MPTB_ST_TB_EVENT]
				&& !(wr_status && reg_wdata_in[MPTB_ST_TB_EVENT]));
			status[MPTB_ST_SPECIAL] <= special_hit
				|| (status[MPTB_ST_SPECIAL]
				&& !(wr_status && reg_wdata_in[MPTB_ST_SPECIAL]));
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mask <= '0;
		end else if (reg_write_in && reg_addr_in == MPTB_REG_MASK) begin
			mask <= reg_wdata_in[MPTB_ST_W-1:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(status & mask);
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			special_trigger_out <= 1'b0;
		end else begin
			special_trigger_out <= special_hit;
		end
	end

	// duty compare: edge-aligned or center-aligned by mode
	assign center_mode = is_updown;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (duty[i] == MPTB_ZERO15) begin
				next_high[i] = 1'b0;
			end else if (center_mode) begin
				next_high[i] = cnt.time_base_count < duty[i]
					|| duty[i] >= period_active;
			end else begin
				next_high[i] = cnt.time_base_count < duty[i];
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pair1_high_out <= 1'b0;
			pair1_low_out <= 1'b1;
			pair2_high_out <= 1'b0;
			pair2_low_out <= 1'b1;
			pair3_high_out <= 1'b0;
			pair3_low_out <= 1'b1;
		end else begin
			pair1_high_out <= next_high[0];
			pair1_low_out <= !next_high[0];
			pair2_high_out <= next_high[1];
			pair2_low_out <= !next_high[1];
			pair3_high_out <= next_high[2];
			pair3_low_out <= !next_high[2];
		end
	end

	// read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= '0;
		end else if (reg_read_in) begin
			unique case (reg_addr_in)
				MPTB_REG_CONTROL: reg_rdata_out <= ctrl;
				MPTB_REG_COUNT: reg_rdata_out <= cnt;
				MPTB_REG_PERIOD: reg_rdata_out <= {1'b0, period_buffer};
				MPTB_REG_EVENT_CMP: reg_rdata_out <= {1'b0, event_cmp};
				MPTB_REG_DUTY1: reg_rdata_out <= {1'b0, duty[0]};
				MPTB_REG_DUTY2: reg_rdata_out <= {1'b0, duty[1]};
				MPTB_REG_DUTY3: reg_rdata_out <= {1'b0, duty[2]};
				MPTB_REG_STATUS: reg_rdata_out <= {14'h0000, status};
				MPTB_REG_MASK: reg_rdata_out <= {14'h0000, mask};
				default: reg_rdata_out <= '0;
			endcase
		end else begin
			reg_rdata_out <= '0;
		end
	end

endmodule // mptb_time_base

//--- verification/mptb_time_base_assertions.sv
// port checker for the motor pwm time base
`timescale 1ns/10ps
module mptb_time_base_assertions
	import mptb_pkg::*;
#(
	parameter int unsigned CNT_W = 15
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [MPTB_ADDR_W-1:0] reg_addr_in,
	input wire logic [MPTB_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [MPTB_DATA_W-1:0] reg_rdata_out,
	input wire logic irq_out,
	input wire logic special_trigger_out,
	input wire logic pair1_high_out,
	input wire logic pair1_low_out,
	input wire logic pair2_high_out,
	input wire logic pair2_low_out,
	input wire logic pair3_high_out,
	input wire logic pair3_low_out
);
	logic on_seen;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// software view of the enable bit; hardware can only clear it
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			on_seen <= 1'b0;
		end else if (reg_write_in && reg_addr_in == MPTB_REG_CONTROL) begin
			on_seen <= reg_wdata_in[15];
		end
	end
	sequence s_mask_off;
		reg_write_in && reg_addr_in == MPTB_REG_MASK && reg_wdata_in[1:0] == 2'h0;
	endsequence
	sequence s_quiet_clear;
		!on_seen && !$past(on_seen) && !$past(on_seen, 2) && reg_write_in
			&& reg_addr_in == MPTB_REG_STATUS && reg_wdata_in[1:0] == 2'h3;
	endsequence
	property p_pair1;
		pair1_low_out == !pair1_high_out;
	endproperty
	property p_pair2;
		pair2_low_out == !pair2_high_out;
	endproperty
	property p_pair3;
		pair3_low_out == !pair3_high_out;
	endproperty
	property p_rdata_idle;
		!reg_read_in |=> reg_rdata_out == 16'h0000;
	endproperty
	property p_unmapped;
		reg_read_in && reg_addr_in > MPTB_REG_MASK |=> reg_rdata_out == 16'h0000;
	endproperty
	property p_irq_mask;
		s_mask_off |-> ##2 !irq_out;
	endproperty
	property p_irq_clear;
		s_quiet_clear |-> ##2 !irq_out;
	endproperty
	property p_trig_off;
		!on_seen && !$past(on_seen) |-> !special_trigger_out;
	endproperty
	a_pair1: assert property (p_pair1) else $error("pair 1 not complementary");
	a_pair2: assert property (p_pair2) else $error("pair 2 not complementary");
	a_pair3: assert property (p_pair3) else $error("pair 3 not complementary");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_irq_mask: assert property (p_irq_mask) else $error("irq with mask off");
	a_irq_clear: assert property (p_irq_clear) else $error("irq after clear");
	a_trig_off: assert property (p_trig_off) else $error("trigger while stopped");
endmodule // mptb_time_base_assertions

bind mptb_time_base mptb_time_base_assertions #(.CNT_W(CNT_W)) u_chk (
	.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
	.reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .special_trigger_out(special_trigger_out),
	.pair1_high_out(pair1_high_out), .pair1_low_out(pair1_low_out),
	.pair2_high_out(pair2_high_out), .pair2_low_out(pair2_low_out),
	.pair3_high_out(pair3_high_out), .pair3_low_out(pair3_low_out));

//--- verification/mptb_time_base_tb.sv
// self-checking bench for the motor pwm time base
`timescale 1ns/10ps
module mptb_time_base_tb
	import mptb_pkg::*;
;
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [15:0] rdata;
	logic irq, trig, trig_seen;
	logic [2:0] hi, lo;
	logic [15:0] rmask [16] = '{0: 16'h00FF, 1: 16'h7FFF, 2: 16'h7FFF, 3: 16'h7FFF,
		4: 16'h7FFF, 5: 16'h7FFF, 6: 16'h7FFF, 8: 16'h0003, default: 16'h0000};
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int t_w, t_r, t_on, p_per, mode_m, sel_m, div_m, mcnt, mdir, men, mpc, mst, msteps;
	int msp, m_cmp, m_duty, hi_e;
	mptb_time_base u_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
		.reg_rdata_out(rdata), .irq_out(irq), .special_trigger_out(trig),
		.pair1_high_out(hi[0]), .pair1_low_out(lo[0]), .pair2_high_out(hi[1]),
		.pair2_low_out(lo[1]), .pair3_high_out(hi[2]), .pair3_low_out(lo[2]));
	initial begin
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (trig !== 1'b0) trig_seen <= 1'b1;
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge ref_clk_in);
		wr_s <= 1'b0;
		t_w = cyc;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge ref_clk_in);
		rd_s <= 1'b0;
		t_r = cyc;
		#1;
		d = rdata;
	endtask
	// model steps taken by edge t-1, prescaler restarted at t_on
	task automatic adv(input int t);
		int ev;
		while (men != 0 && msteps < (t - 1 - t_on) / div_m) begin
			msteps++;
			ev = 0;
			if (mcnt == m_cmp) msp = 1;
			if (mode_m < 2) begin
				ev = (mcnt == p_per);
				mcnt = ev ? 0 : mcnt + 1;
				if (ev && mode_m == 1) men = 0;
			end else if (mdir == 0) begin
				if (mcnt == p_per) begin
					mdir = 1;
					mcnt--;
					ev = (mode_m == 3);
				end else mcnt++;
			end else if (mcnt <= 1) begin
				mcnt = 0;
				mdir = 0;
				ev = 1;
			end else mcnt--;
			if (ev && !mode_m[0] && mpc != sel_m) begin
				mpc++;
			end else if (ev) begin
				mpc = 0;
				mst = 1;
			end
		end
	endtask
	task automatic run(input int m, input int c);
		logic [15:0] d;
		mode_m = m;
		div_m = 1 << (2 * c);
		sel_m = $urandom_range(15);
		p_per = $urandom_range(9, 2);
		m_cmp = $urandom_range(p_per);
		m_duty = $urandom_range(p_per + 1);
		wr(MPTB_REG_CONTROL, 16'h0000);
		wr(MPTB_REG_STATUS, 16'h0003);
		trig_seen = 1'b0;
		wr(MPTB_REG_EVENT_CMP, 16'(m_cmp));
		wr(MPTB_REG_DUTY1, 16'(m_duty));
		wr(MPTB_REG_DUTY2, 16'h0000);
		wr(MPTB_REG_DUTY3, 16'h7FFF);
		wr(MPTB_REG_COUNT, 16'h0000);
		wr(MPTB_REG_PERIOD, 16'(p_per));
		wr(MPTB_REG_CONTROL, {1'b1, 7'h00, 4'(sel_m), 2'(c), 2'(m)});
		t_on = t_w;
		men = 1;
		msteps = 0;
		mcnt = 0;
		mpc = 0;
		mst = 0;
		msp = 0;
		repeat (12) begin
			repeat ($urandom_range(2 * div_m)) @(posedge ref_clk_in);
			rd(MPTB_REG_COUNT, d);
			adv(t_r);
			chk("count", {mdir[0], 15'(mcnt)}, d);
			hi_e = m_duty != 0 && (mcnt < m_duty || (mode_m > 1 && m_duty >= p_per));
			chk("pair1 high", 16'(hi_e), 16'(hi[0]));
			chk("pair1 low", 16'(!hi_e), 16'(lo[0]));
			chk("pair2 high", 16'h0000, 16'(hi[1]));
			chk("pair3 high", 16'h0001, 16'(hi[2]));
		end
		rd(MPTB_REG_CONTROL, d);
		adv(t_r);
		chk("control", {men[0], 7'h00, 4'(sel_m), 2'(c), 2'(m)}, d);
		wr(MPTB_REG_CONTROL, 16'h0000);
		adv(t_w);
		men = 0;
		rd(MPTB_REG_COUNT, d);
		chk("held count", {mdir[0], 15'(mcnt)}, d);
		rd(MPTB_REG_STATUS, d);
		chk("event", 16'(mst), d & 16'h0001);
		chk("special", 16'(msp), (d >> 1) & 16'h0001);
		chk("trigger", 16'(msp), 16'(trig_seen));
		wr(MPTB_REG_MASK, 16'h0001);
		repeat (2) @(posedge ref_clk_in);
		#1 chk("irq", 16'(mst), 16'(irq));
		wr(MPTB_REG_STATUS, 16'h0003);
		repeat (2) @(posedge ref_clk_in);
		#1 chk("irq cleared", 16'h0000, 16'(irq));
	endtask
	initial begin
		repeat (100000) @(posedge ref_clk_in);
		num_errors++;
		end_of_test();
	end
	initial begin
		logic [15:0] d, w;
		void'($urandom(44820));
		trig_seen = 1'b0;
		mdir = 0;
		repeat (10) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			rd(4'(i), d);
			chk("reset value", 16'h0000, d);
		end
		for (int i = 0; i < 16; i++) begin
			w = 16'($urandom()) & 16'h7FFF;
			wr(4'(i), w);
			rd(4'(i), d);
			chk("readback", w & rmask[i], d);
		end
		wr(MPTB_REG_MASK, 16'h0000);
		wr(MPTB_REG_STATUS, 16'h0003);
		wr(MPTB_REG_EVENT_CMP, 16'h0000);
		wr(MPTB_REG_COUNT, 16'h0000);
		wr(MPTB_REG_PERIOD, 16'h0000);
		wr(MPTB_REG_CONTROL, 16'h8000);
		trig_seen = 1'b0;
		wr(MPTB_REG_PERIOD, 16'h0005);
		repeat (20) @(posedge ref_clk_in);
		rd(MPTB_REG_COUNT, d);
		chk("stopped count", 16'h0000, d);
		rd(MPTB_REG_STATUS, d);
		chk("no event", 16'h0000, d);
		chk("no trigger", 16'h0000, 16'(trig_seen));
		for (int m = 0; m < 4; m++) begin
			for (int c = 0; c < 4; c++) begin
				run(m, c);
			end
		end
		end_of_test();
	end
endmodule // mptb_time_base_tb
